/* rtl/nand_host_ctrl.sv */
`timescale 1ns/10ps
`include "nand_host_consts.svh"
module nand_host_ctrl import nand_host_pkg::*; #(
  parameter logic [19:0] P_TR_CYC = 20'(`NH_TR_CYC),
  parameter logic [19:0] P_RST_CYC = 20'(`NH_RST_CYC),
  parameter logic [19:0] P_PROG_CYC = 20'(`NH_PROG_CYC),
  parameter logic [19:0] P_BERS_CYC = 20'(`NH_BERS_CYC),
  // Last block the marker scan visits; the default of 10'h3ff walks every block
  parameter logic [9:0] P_LAST_BLK = `NH_LAST_BLK
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Command port
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire op_e i_cmd_op,
  input wire logic [9:0] i_cmd_blk,
  input wire logic [5:0] i_cmd_page,
  // Program data
  input wire logic [7:0] i_wdata,
  input wire logic i_wvalid,
  output logic o_wready,
  // Read data
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Result
  output logic o_done,
  output res_e o_res,
  output logic [9:0] o_res_blk,
  output logic [5:0] o_res_page,
  output logic o_ecc_single,
  output logic o_ecc_double,
  output logic [13:0] o_ecc_pos,
  // Flash pins
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_read_strobe_n,
  output logic [7:0] o_io,
  output logic o_io_oe,
  input wire logic [7:0] i_io,
  input wire logic i_rb
);
  state_e state;
  op_e op;
  logic [9:0] blk;
  logic [5:0] pg;
  logic [19:0] tc;
  logic [1:0] acnt;
  logic [11:0] col;
  logic mark0;
  logic [9:0] open_blk;
  logic [6:0] next_pg;
  logic [2:0] rb_s;
  logic rb_q;
  logic [7:0] io_s1, io_s2, io_s3, io_q;
  logic [13:0] syn, diff;
  logic par;
  logic [7:0] st_lo;
  logic dv;
  logic [10:0] dcol;
  logic wr_st, rd_st, go, take, byte_end, refuse, bad;
  logic [19:0] wsetup, wlen, limit;
  logic [7:0] wbyte;

  mem_port_if #(.AW(10), .DW(1)) bbt ();
  mem_port_if #(.AW(11), .DW(8)) pbuf ();

  nand_host_ram #(.AW(10), .DW(1)) u_bbt (
    .i_mclk(i_mclk),
    .port(bbt)
  );
  nand_host_ram #(.AW(11), .DW(8)) u_pbuf (
    .i_mclk(i_mclk),
    .port(pbuf)
  );

  // Syndrome of one byte: xor of the bit positions that are set
  function automatic logic [13:0] ecc_byte(input logic [11:0] c, input logic [7:0] d);
    logic [13:0] s;
    s = '0;
    for (int b = 0; b < 8; b++) begin
      if (d[b]) begin
        s = s ^ {c[10:0], 3'(b)};
      end
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge i_mclk) begin
    rb_s <= {rb_s[1:0], i_rb};
    io_s1 <= i_io;
    io_s2 <= io_s1;
    io_s3 <= io_s2;
    if (i_rst) begin
      rb_q <= 1'b0;
      io_q <= 8'h00;
    end else begin
      if (rb_s[1] == rb_s[2]) begin
        rb_q <= rb_s[2];
      end
      if (io_s2 == io_s3) begin
        io_q <= io_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe cycle shape and byte selection
  always_comb begin
    wr_st = (state == S_CMD1) || (state == S_ADDR) || (state == S_WDATA) ||
            (state == S_CMD2) || (state == S_STAT_CMD);
    rd_st = (state == S_RDATA) || (state == S_STAT_RD);
    // Command setup also covers read-strobe-high to write-low recovery
    if (state == S_CMD1) begin
      wsetup = 20'(`NH_RHW_CYC);
    end else if (state == S_WDATA && col == 12'h000) begin
      wsetup = 20'(`NH_ADL_CYC);
    end else begin
      wsetup = 20'(`NH_SETUP_CYC);
    end
    wlen = wsetup + 20'(`NH_WP_CYC) + 20'(`NH_HOLD_CYC);
    take = (state == S_WDATA) && (tc == 20'h00000) && (col < `NH_MARK_COL);
    go = !(take && !i_wvalid);
    // Only strobe states end a byte; waiting states must let tc run to its limits
    byte_end = wr_st ? (tc == wlen - 20'h00001) :
               (rd_st && (tc == 20'(`NH_WHR_CYC + `NH_RDLOW_CYC - 1)));
    bad = (io_q != `NH_ERASED) && (blk != 10'h000);
    // Program and erase of bad blocks, and programs to a page not above the last one written, are turned away
    refuse = ((op == OP_PROG) || (op == OP_ERASE)) &&
             (bbt.rdata[0] ||
              ((op == OP_PROG) && (blk == open_blk) && ({1'b0, pg} < next_pg)));
    case (op)
      OP_READ, OP_SCAN: limit = P_TR_CYC;
      OP_RESET: limit = P_RST_CYC;
      OP_PROG: limit = P_PROG_CYC;
      default: limit = P_BERS_CYC;
    endcase
    limit = limit + 20'(`NH_WB_CYC);
    wbyte = 8'h00;
    case (state)
      S_CMD1: begin
        case (op)
          OP_RESET: wbyte = `NH_C_RESET;
          OP_PROG: wbyte = `NH_C_PROG1;
          OP_ERASE: wbyte = `NH_C_ERASE1;
          default: wbyte = `NH_C_READ1;
        endcase
      end
      S_ADDR: begin
        case (acnt)
          2'h0: wbyte = col[7:0];
          2'h1: wbyte = {4'h0, col[11:8]};
          2'h2: wbyte = {blk[1:0], pg};
          default: wbyte = blk[9:2];
        endcase
      end
      S_CMD2: begin
        case (op)
          OP_PROG: wbyte = `NH_C_PROG2;
          OP_ERASE: wbyte = `NH_C_ERASE2;
          default: wbyte = `NH_C_READ2;
        endcase
      end
      S_STAT_CMD: wbyte = `NH_C_STATUS;
      S_WDATA: begin
        if (col < `NH_MARK_COL) begin
          wbyte = i_wdata;
        end else if (col == `NH_MARK_COL) begin
          wbyte = `NH_ERASED; // Leaves the marker column erased
        end else if (col == `NH_ECC_LO_COL) begin
          wbyte = syn[7:0];
        end else begin
          wbyte = {par, 1'b1, syn[13:8]};
        end
      end
      default: wbyte = 8'h00;
    endcase
  end

  // Memory ports: the table is looked up with the incoming block
  always_comb begin
    bbt.addr = (state == S_IDLE) ? i_cmd_blk : blk;
    bbt.we = 1'b0;
    bbt.wdata = 1'b1;
    if (state == S_RDATA && byte_end && op == OP_SCAN && pg == 6'h01) begin
      bbt.we = 1'b1;
      bbt.wdata = mark0 | bad;
    end else if (state == S_STAT_RD && byte_end && io_q[`NH_ST_FAIL]) begin
      bbt.we = 1'b1;
    end
    pbuf.addr = col[10:0];
    pbuf.wdata = io_q;
    pbuf.we = (state == S_RDATA) && byte_end && (op == OP_READ) && (col < `NH_MARK_COL);
  end

  assign o_cmd_ready = (state == S_IDLE);
  assign o_wready = take;

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= S_IDLE;
      op <= OP_RESET;
      blk <= 10'h000;
      pg <= 6'h00;
      tc <= 20'h00000;
      acnt <= 2'h0;
      col <= 12'h000;
      mark0 <= 1'b0;
      o_res <= RES_OK;
      o_done <= 1'b0;
      o_res_blk <= 10'h000;
      o_res_page <= 6'h00;
    end else begin
      o_done <= 1'b0;
      if (go) begin
        tc <= tc + 20'h00001;
      end
      if (byte_end) begin
        tc <= 20'h00000;
      end
      case (state)
        S_IDLE: begin
          tc <= 20'h00000;
          if (i_cmd_valid) begin
            op <= i_cmd_op;
            blk <= i_cmd_blk;
            pg <= i_cmd_page;
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          tc <= 20'h00000;
          if (op == OP_SCAN) begin
            blk <= 10'h000;
            pg <= 6'h00;
            state <= S_CMD1;
          end else if (refuse) begin
            o_res <= RES_REFUSED;
            state <= S_FINISH;
          end else begin
            state <= S_CMD1;
          end
        end
        S_CMD1: begin
          if (byte_end) begin
            acnt <= (op == OP_ERASE) ? 2'h2 : 2'h0;
            col <= (op == OP_SCAN) ? `NH_MARK_COL : 12'h000;
            state <= (op == OP_RESET) ? S_WAIT : S_ADDR;
          end
        end
        S_ADDR: begin
          if (byte_end) begin
            acnt <= acnt + 2'h1;
            if (acnt == 2'h3) begin
              state <= (op == OP_PROG) ? S_WDATA : S_CMD2;
            end
          end
        end
        S_WDATA: begin
          if (byte_end) begin
            col <= col + 12'h001;
            if (col == `NH_LAST_COL) begin
              state <= S_CMD2;
            end
          end
        end
        S_CMD2: begin
          if (byte_end) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Busy is ignored until it has had time to rise and cross the synchroniser
          if (tc >= 20'(`NH_WB_CYC) && rb_q) begin
            tc <= 20'h00000;
            if (op == OP_RESET) begin
              o_res <= RES_OK;
              state <= S_FINISH;
            end else if (op == OP_READ || op == OP_SCAN) begin
              state <= S_RDATA;
            end else begin
              state <= S_STAT_CMD;
            end
          end else if (tc == limit) begin
            tc <= 20'h00000;
            o_res <= RES_TIMEOUT;
            state <= S_FINISH;
          end
        end
        S_STAT_CMD: begin
          if (byte_end) begin
            state <= S_STAT_RD;
          end
        end
        S_STAT_RD: begin
          if (byte_end) begin
            o_res <= io_q[`NH_ST_FAIL] ? RES_FAIL : RES_OK;
            state <= S_FINISH;
          end
        end
        S_RDATA: begin
          if (byte_end) begin
            col <= col + 12'h001;
            if (op == OP_SCAN) begin
              if (pg == 6'h00) begin
                mark0 <= bad;
                pg <= 6'h01;
                state <= S_CMD1;
              end else if (blk == P_LAST_BLK) begin
                o_res <= RES_OK;
                state <= S_FINISH;
              end else begin
                blk <= blk + 10'h001;
                pg <= 6'h00;
                state <= S_CMD1;
              end
            end else if (col == `NH_LAST_COL) begin
              col <= 12'h000;
              o_res <= RES_OK;
              state <= S_DELIVER;
            end
          end
        end
        S_DELIVER: begin
          col <= col + 12'h001;
          if (col == `NH_MARK_COL - 12'h001) begin
            tc <= 20'h00000;
            state <= S_FINISH;
          end
        end
        S_FINISH: begin
          if (tc == 20'(`NH_RHW_CYC)) begin
            o_done <= 1'b1;
            o_res_blk <= blk;
            o_res_page <= pg;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, registered; controls only move while the write strobe is high
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ce_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_io <= 8'h00;
      o_io_oe <= 1'b0;
    end else begin
      o_ce_n <= !(wr_st || rd_st || state == S_WAIT);
      o_cle <= (state == S_CMD1) || (state == S_CMD2) || (state == S_STAT_CMD);
      o_ale <= (state == S_ADDR);
      o_we_n <= !(wr_st && go && tc >= wsetup && tc < wsetup + 20'(`NH_WP_CYC));
      o_read_strobe_n <= !(rd_st && tc >= 20'(`NH_WHR_CYC));
      o_io_oe <= wr_st;
      if (wr_st && tc == 20'h00000 && go) begin
        o_io <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error code: built while programming, checked and applied on reads
  always_ff @(posedge i_mclk) begin
    if (i_rst || state == S_CHECK) begin
      syn <= 14'h0000;
      par <= 1'b0;
      st_lo <= 8'h00;
    end else if (take && i_wvalid) begin
      syn <= syn ^ ecc_byte(col, i_wdata);
      par <= par ^ (^i_wdata);
    end else if (state == S_RDATA && byte_end && op == OP_READ) begin
      if (col < `NH_MARK_COL) begin
        syn <= syn ^ ecc_byte(col, io_q);
        par <= par ^ (^io_q);
      end else if (col == `NH_ECC_LO_COL) begin
        st_lo <= io_q;
      end else if (col == `NH_LAST_COL) begin
        // Parity mismatch means one flipped bit, at the syndrome's position
        diff <= syn ^ {io_q[5:0], st_lo};
        o_ecc_single <= par ^ io_q[7];
        o_ecc_double <= !(par ^ io_q[7]) && (syn != {io_q[5:0], st_lo});
      end
    end
    if (i_rst) begin
      diff <= 14'h0000;
      o_ecc_single <= 1'b0;
      o_ecc_double <= 1'b0;
    end
  end

  // Corrected stream out of the page buffer; the block is never retired here
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dv <= 1'b0;
      dcol <= 11'h000;
      o_rvalid <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      dv <= (state == S_DELIVER);
      dcol <= col[10:0];
      o_rvalid <= dv;
      if (dv) begin
        o_rdata <= pbuf.rdata ^ ((o_ecc_single && diff[13:3] == dcol) ?
                   8'(8'h01 << diff[2:0]) : 8'h00);
      end
    end
  end
  assign o_ecc_pos = diff;

  // Ascending page tracking for the block being written
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      open_blk <= 10'h000;
      next_pg <= 7'h00;
    end else if (state == S_CHECK && !refuse && op == OP_PROG) begin
      open_blk <= blk;
      next_pg <= {1'b0, pg} + 7'h01;
    end else if (state == S_CHECK && !refuse && op == OP_ERASE) begin
      open_blk <= blk;
      next_pg <= 7'h00;
    end
  end
endmodule

/* rtl/nand_host_consts.svh */
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH
// Clock and rounding
`define NH_CLK_NS 4
`define NH_CYC_UP(ns) (((ns) + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_CYC_DN(us) (((us) * 1000) / `NH_CLK_NS)
// Strobe times in ns, always the slower supply variant
`define NH_T_SETUP_NS 35
`define NH_T_WP_NS 25
`define NH_T_HOLD_NS 15
`define NH_T_ADL_NS 100
`define NH_T_REA_NS 30
`define NH_T_WHR_NS 60
`define NH_T_RHW_NS 100
`define NH_T_WB_NS 100
`define NH_SYNC_CYC 3
`define NH_SETUP_CYC `NH_CYC_UP(`NH_T_SETUP_NS)
`define NH_WP_CYC `NH_CYC_UP(`NH_T_WP_NS)
`define NH_HOLD_CYC `NH_CYC_UP(`NH_T_HOLD_NS)
`define NH_ADL_CYC `NH_CYC_UP(`NH_T_ADL_NS)
`define NH_WHR_CYC `NH_CYC_UP(`NH_T_WHR_NS)
`define NH_RHW_CYC `NH_CYC_UP(`NH_T_RHW_NS)
`define NH_WB_CYC (`NH_CYC_UP(`NH_T_WB_NS) + `NH_SYNC_CYC + 1)
// Read strobe low long enough for access time plus the input synchroniser
`define NH_RDLOW_CYC (`NH_CYC_UP(`NH_T_REA_NS) + `NH_SYNC_CYC + 2)
// Busy limits in us
`define NH_T_R_US 25
`define NH_T_RST_US 500
`define NH_T_PROG_US 700
`define NH_T_BERS_US 3000
`define NH_TR_CYC `NH_CYC_DN(`NH_T_R_US)
`define NH_RST_CYC `NH_CYC_DN(`NH_T_RST_US)
`define NH_PROG_CYC `NH_CYC_DN(`NH_T_PROG_US)
`define NH_BERS_CYC `NH_CYC_DN(`NH_T_BERS_US)
// Command codes
`define NH_C_READ1 8'h00
`define NH_C_READ2 8'h30
`define NH_C_PROG1 8'h80
`define NH_C_PROG2 8'h10
`define NH_C_ERASE1 8'h60
`define NH_C_ERASE2 8'hd0
`define NH_C_STATUS 8'h70
`define NH_C_RESET 8'hff
// Page layout
`define NH_MARK_COL 12'h800
`define NH_ECC_LO_COL 12'h801
`define NH_LAST_COL 12'h802
`define NH_ERASED 8'hff
`define NH_LAST_BLK 10'h3ff
`define NH_ST_FAIL 0
`endif

/* rtl/nand_host_pkg.sv */
package nand_host_pkg;
  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_READ = 3'h1,
    OP_PROG = 3'h2,
    OP_ERASE = 3'h3,
    OP_SCAN = 3'h4
  } op_e;
  typedef enum logic [1:0] {
    RES_OK = 2'h0,
    RES_FAIL = 2'h1,
    RES_REFUSED = 2'h2,
    RES_TIMEOUT = 2'h3
  } res_e;
  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_CHECK = 12'h002,
    S_CMD1 = 12'h004,
    S_ADDR = 12'h008,
    S_WDATA = 12'h010,
    S_CMD2 = 12'h020,
    S_WAIT = 12'h040,
    S_STAT_CMD = 12'h080,
    S_STAT_RD = 12'h100,
    S_RDATA = 12'h200,
    S_DELIVER = 12'h400,
    S_FINISH = 12'h800
  } state_e;
endpackage

/* rtl/mem_port_if.sv */
`timescale 1ns/10ps
interface mem_port_if #(parameter int AW = 10, parameter int DW = 1);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* rtl/nand_host_ram.sv */
`timescale 1ns/10ps
module nand_host_ram #(
  parameter int AW = 10,
  parameter int DW = 1
) (
  // Clock
  input wire logic i_mclk,
  // Access port
  mem_port_if.mem port
);
  logic [DW-1:0] mem [2**AW];

  // Single port, registered read data
  always_ff @(posedge i_mclk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end
endmodule

/* testbench/nand_flash_model.sv */
`timescale 1ns/10ps
// Flash part model: latches on the write strobe rise, busy times well inside limits
module nand_flash_model #(
  parameter int FAIL_BLK = 7,
  parameter int FAIL_PAGE = 1
) (
  // Control pins
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  // Data pins
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_rb
);
  logic [7:0] mem [int];
  logic [7:0] pg [0:2111];
  logic [7:0] cmd;
  logic [7:0] stat;
  logic [15:0] col;
  logic [15:0] row;
  int na;
  int q [$];
  function automatic int key(int b, int p, int c);
    return (b << 18) | (p << 12) | c;
  endfunction
  function automatic logic [7:0] rd(int k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction
  task automatic busy(int ns);
    #20 o_rb = 1'b0;
    #(ns) o_rb = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Factory marks sit at column 2048; block zero never gets one
  initial begin
    o_rb = 1'b1;
    o_io = 8'h5a;
    mem[key(5, 0, 2048)] = 8'h00;
    mem[key(9, 1, 2048)] = 8'h3c;
  end
  // Command, address and data latch
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      cmd = i_io;
      na = (cmd == 8'h60) ? 2 : 0;
      if (cmd == 8'h80) pg = '{default: 8'hff};
      if (cmd == 8'h30) begin
        for (int c = 0; c < 2112; c++) pg[c] = rd(key(row[15:6], row[5:0], c));
        busy(200);
      end
      if (cmd == 8'h10) begin
        stat = (row == {10'(FAIL_BLK), 6'(FAIL_PAGE)}) ? 8'he1 : 8'he0;
        for (int c = 0; c < 2112 && !stat[0]; c++) begin
          if (pg[c] != 8'hff) mem[key(row[15:6], row[5:0], c)] = rd(key(row[15:6], row[5:0], c)) & pg[c];
        end
        busy(800);
      end
      if (cmd == 8'hd0) begin
        stat = 8'he0;
        foreach (mem[k]) if ((k >> 18) == int'(row[15:6])) q.push_back(k);
        while (q.size() > 0) mem.delete(q.pop_front());
        busy(1000);
      end
      if (cmd == 8'hff) busy(3000);
    end else if (!i_ce_n && i_ale) begin
      if (na < 2) col[na*8 +: 8] = i_io;
      else row[(na-2)*8 +: 8] = i_io;
      na++;
    end else if (!i_ce_n) begin
      pg[col] = i_io;
      col++;
    end
  end
  // Output; a released bus flips so no stale byte can be mistaken for data
  always @(i_re_n or i_ce_n) begin
    if (!i_re_n && !i_ce_n) o_io = (cmd == 8'h70) ? stat : pg[col];
    else o_io = ~o_io;
  end
  always @(posedge i_re_n) if (!i_ce_n && cmd != 8'h70) col++;
endmodule

/* testbench/nand_host_ctrl_properties.sv */
`timescale 1ns/10ps
module nand_host_ctrl_checker import nand_host_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Flash pins
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_read_strobe_n,
  input wire logic o_io_oe,
  input wire logic i_rb,
  // Results
  input wire logic o_done,
  input wire res_e o_res,
  input wire logic o_rvalid
);
  logic [7:0] since_we_up;
  logic [7:0] since_we_dn;
  logic [7:0] since_re_up;
  logic last_addr;
  function automatic logic [7:0] sat(logic [7:0] c, logic ev);
    return ev ? 8'h00 : ((c == 8'hff) ? c : c + 8'h01);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Edges counted since each strobe moved; saturation keeps long gaps large
  always_ff @(posedge i_mclk) begin
    since_we_up <= i_rst ? 8'hff : sat(since_we_up, $rose(o_we_n));
    since_we_dn <= i_rst ? 8'hff : sat(since_we_dn, $fell(o_we_n));
    since_re_up <= i_rst ? 8'hff : sat(since_re_up, $rose(o_read_strobe_n));
  end
  // Kind of the latest latch cycle
  always_ff @(posedge i_mclk) begin
    last_addr <= i_rst ? 1'b0 : ($rose(o_we_n) ? o_ale : last_addr);
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_adl_gap;
    $rose(o_we_n) && last_addr && !o_ale && !o_cle && o_io_oe |-> since_we_up >= 8'h18;
  endproperty
  a_adl_gap: assert property (p_adl_gap) else $error("address to data gap short");
  property p_ctl_still;
    !o_we_n && !$past(o_we_n) |-> $stable({o_cle, o_ale, o_ce_n});
  endproperty
  a_ctl_still: assert property (p_ctl_still) else $error("control moved in pulse");
  property p_cle_ale;
    !(o_cle && o_ale);
  endproperty
  a_cle_ale: assert property (p_cle_ale) else $error("both latch enables high");
  property p_we_low;
    $fell(o_we_n) |-> !o_we_n [*7];
  endproperty
  a_we_low: assert property (p_we_low) else $error("write pulse too short");
  property p_we_high;
    $rose(o_we_n) |-> o_we_n [*4];
  endproperty
  a_we_high: assert property (p_we_high) else $error("write high too short");
  property p_rhw;
    $fell(o_we_n) |-> since_re_up >= 8'h18;
  endproperty
  a_rhw: assert property (p_rhw) else $error("read to write gap short");
  property p_quiet_busy;
    !i_rb [*6] |-> o_we_n && o_read_strobe_n;
  endproperty
  a_quiet_busy: assert property (p_quiet_busy) else $error("strobe while busy");
  property p_refused;
    o_done && o_res == RES_REFUSED |-> since_we_dn >= 8'h1b;
  endproperty
  a_refused: assert property (p_refused) else $error("refused op touched pins");
  property p_burst;
    $rose(o_rvalid) |-> o_rvalid [*8];
  endproperty
  a_burst: assert property (p_burst) else $error("read stream broke up");
endmodule

bind nand_host_ctrl nand_host_ctrl_checker i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n), .o_io_oe(o_io_oe),
  .o_read_strobe_n(o_read_strobe_n), .i_rb(i_rb), .o_done(o_done), .o_res(o_res),
  .o_rvalid(o_rvalid));

/* testbench/nand_timing_and_bad_block_handling_bench.sv */
`timescale 1ns/10ps
module nand_timing_and_bad_block_handling_bench import nand_host_pkg::*;;
  typedef struct {res_e res; logic [9:0] blk; logic [5:0] page; logic loc; logic ecc;
    logic [1:0] flags; logic [13:0] pos;} note_s;
  logic i_mclk, i_rst, i_cmd_valid, i_wvalid, i_rb, skip_data;
  logic o_cmd_ready, o_wready, o_rvalid, o_done, o_ecc_single, o_ecc_double;
  logic o_ce_n, o_cle, o_ale, o_we_n, o_read_strobe_n, o_io_oe;
  logic [7:0] i_wdata, o_rdata, o_io, i_io, dq;
  logic [9:0] i_cmd_blk, o_res_blk;
  logic [5:0] i_cmd_page, o_res_page;
  logic [13:0] o_ecc_pos;
  op_e i_cmd_op;
  res_e o_res;
  int fails, n_compared, c, b, k;
  int unsigned s [4];
  note_s notes [$];
  logic [7:0] bytes [$];
  // Bus level: host drives while enabled, otherwise the flash
  assign i_io = o_io_oe ? o_io : dq;
  nand_host_ctrl #(.P_TR_CYC(20'h000c8), .P_RST_CYC(20'h007d0), .P_PROG_CYC(20'h003e8),
    .P_BERS_CYC(20'h003e8), .P_LAST_BLK(10'h00f)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid),
    .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_blk(i_cmd_blk),
    .i_cmd_page(i_cmd_page), .i_wdata(i_wdata), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_done(o_done), .o_res(o_res),
    .o_res_blk(o_res_blk), .o_res_page(o_res_page), .o_ecc_single(o_ecc_single),
    .o_ecc_double(o_ecc_double), .o_ecc_pos(o_ecc_pos), .o_ce_n(o_ce_n), .o_cle(o_cle),
    .o_ale(o_ale), .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .o_io(o_io),
    .o_io_oe(o_io_oe), .i_io(i_io), .i_rb(i_rb));
  nand_flash_model i_flash (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_re_n(o_read_strobe_n), .i_io(i_io), .o_io(dq), .o_rb(i_rb));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dat(int unsigned sd, int col);
    return 8'(sd >> (col % 23)) ^ 8'(col * 7);
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  // One command: note the expectation, hand it over, feed data, wait for done
  task automatic run(op_e op, int bk, int p, res_e r, int unsigned sd = 0, logic [15:0] e = 0);
    int n;
    notes.push_back('{r, 10'(bk), 6'(p), op != OP_SCAN && op != OP_RESET, op == OP_READ,
      e[15:14], e[13:0]});
    if (op == OP_READ && !skip_data) for (int i = 0; i < 2048; i++) bytes.push_back(dat(sd, i));
    i_cmd_op = op;
    i_cmd_blk = 10'(bk);
    i_cmd_page = 6'(p);
    i_cmd_valid = 1'b1;
    while (o_cmd_ready !== 1'b1) tick();
    tick();
    i_cmd_valid = 1'b0;
    for (int i = 0; i < 2048 && op == OP_PROG && r != RES_REFUSED; i++) begin
      i_wdata = dat(sd, i);
      i_wvalid = 1'b1;
      while (o_wready !== 1'b1) tick();
      tick();
    end
    i_wvalid = 1'b0;
    for (n = 0; n < 400000 && o_done !== 1'b1; n++) tick();
    if (n < 400000) begin
      tick();
    end else begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note per done pulse, oldest byte per read beat
  always @(posedge i_mclk) begin
    if (o_rvalid === 1'b1 && !skip_data) check(o_rdata, bytes.pop_front(), "byte");
    if (o_done === 1'b1) begin
      note_s n;
      n = notes.pop_front();
      check(o_res, n.res, "result");
      if (n.loc) check({o_res_blk, o_res_page}, {n.blk, n.page}, "place");
      if (n.ecc) check({o_ecc_single, o_ecc_double, (n.flags == 2'b10) ? o_ecc_pos : 14'h0},
        {n.flags, n.pos}, "ecc");
    end
  end
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // Watchdog sized well past the whole run; the longest single path is a full page read
  initial begin
    #10000000;
    fails++;
    print_verdict();
  end
  initial begin
    {i_rst, i_cmd_valid, i_wvalid, skip_data} = 4'hc;
    {i_cmd_blk, i_cmd_page, i_wdata} = 24'h0;
    i_cmd_op = OP_RESET;
    {fails, n_compared} = 64'h0;
    s[0] = $urandom(32'h3cca);
    foreach (s[i]) s[i] = $urandom();
    repeat (12) tick();
    i_rst = 1'b0;
    run(OP_RESET, 0, 0, RES_OK);
    run(OP_SCAN, 0, 0, RES_OK);
    $display("test reset_and_scan finished");
    // Marked blocks get neither erase nor program
    for (k = 0; k < 2; k++) run(OP_ERASE, 5 + 4 * k, 0, RES_REFUSED);
    run(OP_PROG, 5, 0, RES_REFUSED);
    run(OP_PROG, 9, 0, RES_REFUSED);
    $display("test marked_blocks finished");
    // Block zero in use; pages only upward, a repeat of the last page too
    run(OP_ERASE, 0, 0, RES_OK);
    run(OP_PROG, 0, 0, RES_OK, s[0]);
    run(OP_PROG, 0, 1, RES_OK, s[1]);
    run(OP_PROG, 0, 1, RES_REFUSED);
    run(OP_PROG, 0, 0, RES_REFUSED);
    run(OP_READ, 0, 1, RES_OK, s[1], 16'h0);
    $display("test ascending_pages finished");
    // One flipped bit is repaired in place, a second one is only reported
    c = $urandom_range(2047);
    b = $urandom_range(7);
    i_flash.mem[i_flash.key(0, 0, c)] = i_flash.rd(i_flash.key(0, 0, c)) ^ (8'h01 << b);
    run(OP_READ, 0, 0, RES_OK, s[0], {2'b10, 11'(c), 3'(b)});
    c = (c + 1 + $urandom_range(99)) % 2048;
    i_flash.mem[i_flash.key(0, 0, c)] = i_flash.rd(i_flash.key(0, 0, c)) ^ 8'h10;
    skip_data = 1'b1;
    run(OP_READ, 0, 0, RES_OK, s[0], 16'h4000);
    skip_data = 1'b0;
    $display("test ecc_errors finished");
    // Program failure retires the block; the user rebuilds it elsewhere
    run(OP_ERASE, 7, 0, RES_OK);
    run(OP_PROG, 7, 0, RES_OK, s[2]);
    run(OP_PROG, 7, 1, RES_FAIL, s[3]);
    run(OP_PROG, 7, 2, RES_REFUSED);
    run(OP_ERASE, 7, 0, RES_REFUSED);
    run(OP_ERASE, 3, 0, RES_OK);
    run(OP_PROG, 3, 0, RES_OK, s[2]);
    run(OP_PROG, 3, 1, RES_OK, s[3]);
    run(OP_READ, 3, 1, RES_OK, s[3], 16'h0);
    $display("test block_replacement finished");
    print_verdict();
  end
endmodule
